// [include/charger_regs_pkg.sv]
// register map constants, field layout and carrier types for the
// charger control byte registers.
// assumes a byte-wide host access port decoded by 8-bit offset.
//
// Functional notes
// - a set mask bit keeps its fault event from asserting the interrupt
// - mask bits: 7 bat ov, 6 bat oc, 5 bus ov, 4 bus oc, 3..0 temps
// - mask register at 0x12, read/write, reset zero, watchdog leaves it
// - part register 0x13: 4-bit code in [3:0], upper bits fixed
// - register reset clears control bits 7..2 and 0; bit 1 reads zero
// - bit 7 enables converter; bit 6 selects continuous or one-shot
// - bit 5 selects running average; bit 4 zero seeds from stored result
// - bit 4 set seeds the running average from a fresh conversion
// - bits 3:2 select resolution 15,14,13,12 bits; reset 00
// - bit 0 set skips input-current channel conversion
// - fault flags latch events, clear on flag read; mask not involved
package charger_regs_pkg;
   localparam logic [7:0] flag_offset       = 8'h11;
   localparam logic [7:0] mask_offset       = 8'h12;
   localparam logic [7:0] part_offset       = 8'h13;
   localparam logic [7:0] control_offset    = 8'h14;
   localparam logic [7:0] mask_reset        = 8'h00;
   localparam logic [7:0] control_reset     = 8'h00;
   // upper nibble of the part byte is fixed at 0001
   localparam logic [3:0] part_upper_fixed  = 4'h1;
   // arbitrary identification value, not a real part
   localparam logic [3:0] part_code_default = 4'h5;
   localparam int         enable_bit        = 7;
   localparam int         rate_bit          = 6;
   localparam int         average_bit       = 5;
   localparam int         seed_bit          = 4;
   localparam int         speed_msb         = 3;
   localparam int         speed_lsb         = 2;
   localparam int         reserved_bit      = 1;
   localparam int         current_off_bit   = 0;
   // every bit but reserved bit 1 is writable; bit 1 stays zero
   localparam logic [7:0] control_writable  = 8'hfd;
   localparam logic [7:0] control_wd_clear  = 8'h80;

   typedef struct packed {
      logic battery_overvoltage_mask;
      logic battery_overcurrent_mask;
      logic input_overvoltage_mask;
      logic input_overcurrent_mask;
      logic temp_sense_alarm_mask;
      logic battery_overtemp_mask;
      logic connector_overtemp_mask;
      logic die_overtemp_mask;
   } fault_bits_t;

   typedef struct packed {
      logic       converter_enable;
      logic       one_shot;
      logic       averaging_select;
      logic       averaging_seed_select;
      logic [1:0] sample_speed;
      logic       input_current_channel_off;
   } converter_cfg_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_access_t;
endpackage

// [logic/charger_control_regs.sv]
// fault mask, part identification and converter control registers of
// the charger, with fault flag latching and converter sequencing.
// assumes a host bridge presenting one-cycle byte reads and writes, and
// fault and converter status inputs synchronous to sys_clk except the
// fault inputs, which come from analog comparators and are synchronised.
`timescale 1ns/1ps
module charger_control_regs (
   input  wire logic                             sys_clk,
   input  wire logic                             rst,
   input  wire logic                             reg_reset,
   input  wire logic                             watchdog_expired,
   input  wire charger_regs_pkg::host_access_t   host,
   output charger_regs_pkg::fault_bits_t         fault_events_async_unused,
   input  wire charger_regs_pkg::fault_bits_t    fault_events,
   input  wire logic                             pass_done,
   output logic [7:0]                            rdata,
   output logic                                  rvalid,
   output logic                                  int_n,
   output charger_regs_pkg::converter_cfg_t      converter_cfg,
   output logic                                  converter_run,
   output logic                                  seed_from_fresh
);
   import charger_regs_pkg::*;

   typedef enum {conv_idle, conv_running, conv_stopped} conv_state_t;

   fault_bits_t    mask_reg;
   logic [7:0]     control_reg;
   fault_bits_t    sync1, sync2, sync3, stable;
   fault_bits_t    flags, irq_req;
   conv_state_t    state, next_state;
   logic           int_pulse_hold;

   wire            write_mask    = host.wr && host.addr == mask_offset;
   wire            write_control = host.wr && host.addr == control_offset;
   wire            read_flags    = host.rd && host.addr == flag_offset;
   wire            enabled       = control_reg[enable_bit];
   wire            one_shot      = control_reg[rate_bit];
   wire            any_irq       = |irq_req;
   wire [7:0]      part_byte     = {part_upper_fixed, part_code_default};
   logic [7:0]     next_rdata;

   // three-stage synchroniser; a change counts once stages 2 and 3 agree
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         stable <= '0;
      end else begin
         sync1 <= fault_events;
         sync2 <= sync1;
         sync3 <= sync2;
         stable <= (sync2 == sync3) ? sync3 : stable;
      end
   end

   for (genvar i = 0; i < 8; i++) begin : g_flag
      fault_flag_cell u_cell (
         .sys_clk       (sys_clk),
         .rst           (rst),
         .reg_reset     (reg_reset),
         .event_in      (stable[i]),
         .clear_on_read (read_flags),
         .mask          (mask_reg[i]),
         .flag          (flags[i]),
         .irq_request   (irq_req[i])
      );
   end

   // mask register: register reset clears, watchdog has no effect
   always_ff @(posedge sys_clk) begin
      if (rst || reg_reset) begin
         mask_reg <= mask_reset;
      end else if (write_mask) begin
         mask_reg <= host.wdata;
      end
   end

   // control register; bit 1 never stored
   always_ff @(posedge sys_clk) begin
      if (rst || reg_reset) begin
         control_reg <= control_reset;
      end else if (write_control) begin
         control_reg <= host.wdata & control_writable;
      end else if (watchdog_expired) begin
         control_reg <= control_reg & ~control_wd_clear;
      end else if (state == conv_running && next_state == conv_stopped) begin
         // one-shot done: drop enable so the host sees the stop
         control_reg <= control_reg & ~control_wd_clear;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         conv_idle: begin
            if (enabled) begin
               next_state = conv_running;
            end
         end
         conv_running: begin
            if (!enabled) begin
               next_state = conv_idle;
            end else if (one_shot && pass_done) begin
               next_state = conv_stopped;
            end
         end
         conv_stopped: begin
            // wait for a new request or continuous mode
            if (enabled && (write_control || !one_shot)) begin
               next_state = conv_running;
            end else if (!enabled) begin
               next_state = conv_idle;
            end
         end
         default: next_state = conv_idle;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst || reg_reset) begin
         state <= conv_idle;
      end else begin
         state <= next_state;
      end
   end

   always_comb begin
      case (host.addr)
         flag_offset:    next_rdata = flags;
         mask_offset:    next_rdata = mask_reg;
         part_offset:    next_rdata = part_byte;
         control_offset: next_rdata = control_reg;
         default:        next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
         int_n <= 1'b1;
         int_pulse_hold <= 1'b0;
         converter_cfg <= '0;
         converter_run <= 1'b0;
         seed_from_fresh <= 1'b0;
         fault_events_async_unused <= '0;
      end else begin
         rdata <= host.rd ? next_rdata : rdata;
         rvalid <= host.rd;
         int_pulse_hold <= any_irq;
         int_n <= ~(any_irq | int_pulse_hold);
         converter_cfg <= '{
            converter_enable:          control_reg[enable_bit],
            one_shot:                  control_reg[rate_bit],
            averaging_select:          control_reg[average_bit],
            averaging_seed_select:     control_reg[seed_bit],
            sample_speed:              control_reg[speed_msb:speed_lsb],
            input_current_channel_off: control_reg[current_off_bit]
         };
         converter_run <= next_state == conv_running;
         // fresh seed only when averaging and bit 4 requests it
         seed_from_fresh <= control_reg[average_bit] & control_reg[seed_bit];
         fault_events_async_unused <= '0;
      end
   end
endmodule

// [logic/fault_flag_cell.sv]
// one latching fault flag with mask gating toward the interrupt.
// assumes the event is already synchronous to sys_clk.
`timescale 1ns/1ps
module fault_flag_cell (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic reg_reset,
   input  wire logic event_in,
   input  wire logic clear_on_read,
   input  wire logic mask,
   output logic      flag,
   output logic      irq_request
);
   logic rise;
   logic event_prev;
   // a new occurrence only, so a persisting fault raises one interrupt
   assign rise = event_in & ~event_prev;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         event_prev <= 1'b0;
      end else begin
         event_prev <= event_in;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst || reg_reset) begin
         flag <= 1'b0;
      end else if (event_in) begin
         flag <= 1'b1;
      end else if (clear_on_read) begin
         flag <= 1'b0;
      end
   end
   assign irq_request = rise & ~mask;
endmodule

// [testbench/charger_control_regs_sva.sv]
// checker for the charger control register ports.
// assumes a bind onto the top module, single clock domain.
`timescale 1ns/1ps
module charger_control_regs_chk
   import charger_regs_pkg::*;
(
   input wire logic           sys_clk,
   input wire logic           rst,
   input wire logic           reg_reset,
   input wire logic           watchdog_expired,
   input wire host_access_t   host,
   input wire logic           pass_done,
   input wire logic [7:0]     rdata,
   input wire logic           rvalid,
   input wire logic           int_n,
   input wire converter_cfg_t converter_cfg,
   input wire logic           converter_run,
   input wire logic           seed_from_fresh
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence int_pulse;
      !int_n [*2] ##1 int_n;
   endsequence
   chk_read_answer: assert property (host.rd |=> rvalid)
      else $error("read not answered");
   chk_rvalid_cause: assert property (rvalid |-> $past(host.rd))
      else $error("rvalid without read");
   chk_part_byte: assert property (
      rvalid && $past(host.addr) == part_offset
      |-> rdata == {part_upper_fixed, part_code_default})
      else $error("part byte wrong");
   chk_reserved_zero: assert property (
      rvalid && $past(host.addr) == control_offset |-> !rdata[1])
      else $error("reserved control bit set");
   chk_regrst_cfg: assert property (
      reg_reset && !host.wr |-> ##2 converter_cfg == '0)
      else $error("register reset left control bits");
   chk_wdog_enable: assert property (
      watchdog_expired && !host.wr |-> ##2 !converter_cfg.converter_enable)
      else $error("watchdog left enable set");
   chk_seed_fresh: assert property (
      seed_from_fresh == (converter_cfg.averaging_select
                          && converter_cfg.averaging_seed_select))
      else $error("fresh seed select wrong");
   chk_int_pulse: assert property ($fell(int_n) |-> int_pulse)
      else $error("interrupt pulse length wrong");
   chk_oneshot_stop: assert property (
      pass_done && converter_run && converter_cfg.one_shot
      |-> ##[1:3] !converter_run)
      else $error("one-shot pass did not stop");
endmodule

// [testbench/host_model.sv]
// host side model issuing single byte reads and writes.
// assumes the design samples the access port on rising sys_clk.
`timescale 1ns/1ps
module host_model
   import charger_regs_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid,
   output host_access_t    host
);
   initial host = '0;
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      host = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk);
      host.wr = 1'b0;
      // scrambled so nothing leans on a stale byte
      host.wdata = ~d;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d,
                       output bit late);
      late = 1'b1;
      @(negedge sys_clk);
      host.rd = 1'b1;
      host.addr = a;
      for (int i = 0; i < 4 && late; i++) begin
         @(negedge sys_clk);
         host.rd = 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            late = 1'b0;
         end
      end
   endtask
endmodule

// [testbench/tb_charger_control_regs.sv]
// self-checking bench for the charger control registers.
// assumes the host model drives the access port at falling edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_charger_control_regs;
   import charger_regs_pkg::*;
   logic           sys_clk = 1'b0;
   logic           rst = 1'b1;
   logic           reg_reset = 1'b0;
   logic           watchdog_expired = 1'b0;
   logic           pass_done = 1'b0;
   fault_bits_t    fault_events = '0;
   fault_bits_t    spare_out;
   host_access_t   host;
   converter_cfg_t converter_cfg;
   logic [7:0]     rdata;
   logic [7:0]     rd_byte;
   logic           rvalid;
   logic           int_n;
   logic           converter_run;
   logic           seed_from_fresh;
   bit             late;
   int             mismatches = 0;
   int             cmp_count = 0;
   charger_control_regs i_dut (.sys_clk, .rst, .reg_reset,
      .watchdog_expired, .host, .fault_events_async_unused(spare_out),
      .fault_events, .pass_done, .rdata, .rvalid, .int_n,
      .converter_cfg, .converter_run, .seed_from_fresh);
   host_model i_host (.sys_clk, .rdata, .rvalid, .host);
   initial forever #4 sys_clk = ~sys_clk;
   task automatic cycles(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cycles(1);
      s = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      i_host.read(a, rd_byte, late);
      `CHK("read late", 1'b0, late)
      // a lost answer ends the run at once
      if (late) tally_and_finish();
      else `CHK("read byte", e, rd_byte)
   endtask
   task automatic int_seen(input logic e);
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         @(negedge sys_clk);
         if (int_n === 1'b0) seen = 1'b1;
      end
      `CHK("interrupt", e, seen)
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      rd_chk(mask_offset, 8'h00);
      rd_chk(part_offset, {4'h1, part_code_default});
      rd_chk(control_offset, 8'h00);
      i_host.write(part_offset, 8'hff);
      rd_chk(part_offset, {4'h1, part_code_default});
      rd_chk(8'h20, 8'h00);
      i_host.write(mask_offset, 8'ha5);
      rd_chk(mask_offset, 8'ha5);
      i_host.write(control_offset, 8'hff);
      rd_chk(control_offset, 8'hfd);
      `CHK("cfg", 7'h7f, converter_cfg)
      `CHK("seed", 1'b1, seed_from_fresh)
      pulse(watchdog_expired);
      rd_chk(control_offset, 8'h7d);
      rd_chk(mask_offset, 8'ha5);
      for (int s = 0; s < 4; s++) begin
         i_host.write(control_offset, {4'h2, s[1:0], 2'b01});
         cycles(2);
         `CHK("cfg speed", {4'h2, s[1:0], 1'b1}, converter_cfg)
      end
      `CHK("seed off", 1'b0, seed_from_fresh)
      i_host.write(control_offset, 8'h80);
      pulse(pass_done);
      cycles(3);
      `CHK("run cont", 1'b1, converter_run)
      i_host.write(control_offset, 8'hc0);
      cycles(2);
      pulse(pass_done);
      cycles(3);
      `CHK("run stop", 1'b0, converter_run)
      rd_chk(control_offset, 8'h40);
      fault_events = 8'h40;
      int_seen(1'b1);
      fault_events = 8'h00;
      // let the synchroniser drop the event, else the set beats the clear
      cycles(6);
      rd_chk(flag_offset, 8'h40);
      rd_chk(flag_offset, 8'h00);
      fault_events = 8'h80;
      int_seen(1'b0);
      fault_events = 8'h00;
      rd_chk(flag_offset, 8'h80);
      `CHK("spare out", 8'h00, spare_out)
      pulse(reg_reset);
      rd_chk(mask_offset, 8'h00);
      rd_chk(control_offset, 8'h00);
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      `CHK("run time limit", 1'b0, 1'b1)
      tally_and_finish();
   end
endmodule
bind charger_control_regs charger_control_regs_chk i_chk (.sys_clk, .rst,
   .reg_reset, .watchdog_expired, .host, .pass_done, .rdata, .rvalid,
   .int_n, .converter_cfg, .converter_run, .seed_from_fresh);
